/* rtl/dbgcf_pkg.sv */
// shared constants and types for the debug comparator and trace fifo registers
package dbgcf_pkg;

  // ----------------------------------------
  // bus geometry
  // ----------------------------------------
  localparam int DBGCF_AW = 16;
  localparam int DBGCF_DW = 32;
  localparam int DBGCF_IDX_W = 14;

  // ----------------------------------------
  // register indices; byte address is four times the index
  // ----------------------------------------
  localparam logic [DBGCF_IDX_W-1:0] IDX_CMP_B_ADDR_LOW = 14'h18C3;
  localparam logic [DBGCF_IDX_W-1:0] IDX_CMP_C_ADDR_HIGH = 14'h18C4;
  localparam logic [DBGCF_IDX_W-1:0] IDX_CMP_C_ADDR_LOW = 14'h18C5;
  localparam logic [DBGCF_IDX_W-1:0] IDX_TRACE_FIFO_HIGH = 14'h18C6;
  localparam logic [DBGCF_IDX_W-1:0] IDX_TRACE_FIFO_LOW = 14'h18C7;
  localparam logic [DBGCF_IDX_W-1:0] IDX_CMP_A_DIRECTION_EXT = 14'h18C8;
  localparam logic [DBGCF_IDX_W-1:0] IDX_DEBUG_CTRL = 14'h18D0;
  localparam logic [DBGCF_IDX_W-1:0] IDX_FIFO_STATUS = 14'h18D1;

  // ----------------------------------------
  // field layout and reset values
  // ----------------------------------------
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  localparam logic [7:0] CAX_WRITE_MASK = 8'hC0;
  localparam logic [7:0] CTRL_WRITE_MASK = 8'hC3;
  localparam int CAX_DIR_EN_BIT = 7;
  localparam int CAX_DIR_VAL_BIT = 6;
  localparam int CTRL_ENABLE_BIT = 7;
  localparam int CTRL_BEGIN_BIT = 6;
  localparam int CTRL_MODE_LSB = 0;
  localparam int STAT_EMPTY_BIT = 7;
  localparam int STAT_FULL_BIT = 6;

  // trigger mode class kept in the control register
  typedef enum logic [1:0] {
    DBGCF_MODE_ADDR = 2'b00,
    DBGCF_MODE_FULL = 2'b01,
    DBGCF_MODE_EVENT = 2'b10,
    DBGCF_MODE_RANGE = 2'b11
  } dbgcf_mode_t;

  // monitored cpu cycle
  typedef struct packed {
    logic valid;
    logic rw;
    logic [15:0] addr;
  } dbgcf_bus_t;

  // one comparator's setup
  typedef struct packed {
    logic dir_en;
    logic dir_val;
    logic [15:0] addr;
  } dbgcf_cmp_t;

  // byte address of a register index
  function automatic logic [DBGCF_AW-1:0] dbgcf_byte_addr(input logic [DBGCF_IDX_W-1:0] idx);
    dbgcf_byte_addr = {idx, 2'b00};
  endfunction

endpackage

/* rtl/dbgcf_cmp.sv */
// one address comparator with optional read/write qualification
`timescale 1ns/1ps
`default_nettype none
module dbgcf_cmp (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic active,
  input wire dbgcf_pkg::dbgcf_bus_t bus,
  input wire dbgcf_pkg::dbgcf_cmp_t cfg,
  output logic match
);
  import dbgcf_pkg::*;

  // direction value matters only when direction qualification is on
  wire addr_hit = (bus.addr == cfg.addr);
  wire dir_hit = !cfg.dir_en || (bus.rw == cfg.dir_val);
  wire match_next = active && bus.valid && addr_hit && dir_hit;

  // registered so the match output is glitch free
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      match <= 1'b0;
    end else begin
      match <= match_next;
    end
  end

endmodule
`default_nettype wire

/* rtl/dbgcf_mem.sv */
// trace fifo storage with a registered read port
`timescale 1ns/1ps
`default_nettype none
module dbgcf_mem #(
  parameter int WIDTH = 16,
  parameter int AW = 3
) (
  input wire logic clk_sys,
  input wire logic wr_en,
  input wire logic [AW-1:0] wr_addr,
  input wire logic [WIDTH-1:0] wr_data,
  input wire logic [AW-1:0] rd_addr,
  output logic [WIDTH-1:0] rd_data
);
  logic [WIDTH-1:0] mem [0:(1<<AW)-1];

  // storage has no reset; contents are meaningful only behind the pointers
  always_ff @(posedge clk_sys) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
    rd_data <= mem[rd_addr];
  end

endmodule
`default_nettype wire

/* rtl/dbgcf_top.sv */
// debug comparator b/c address bytes, comparator a direction and trace fifo read-out
`timescale 1ns/1ps
`default_nettype none
module dbgcf_top #(
  parameter int FIFO_AW = 3,
  parameter int FIFO_W = 16
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic end_run_reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [dbgcf_pkg::DBGCF_AW-1:0] paddr,
  input wire logic [dbgcf_pkg::DBGCF_DW-1:0] pwdata,
  output logic [dbgcf_pkg::DBGCF_DW-1:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic mcu_secure,
  input wire logic bdm_cmd_active,
  input wire dbgcf_pkg::dbgcf_bus_t cpu_bus,
  input wire logic [15:0] cmp_a_addr,
  input wire logic [7:0] cmp_b_addr_high,
  input wire logic cmp_b_dir_enable,
  input wire logic cmp_b_dir_value,
  input wire logic trace_valid,
  input wire logic [FIFO_W-1:0] trace_word,
  output logic cmp_a_match,
  output logic cmp_b_match,
  output logic cmp_c_match
);
  import dbgcf_pkg::*;

  // ----------------------------------------
  // reset classes
  // ----------------------------------------
  // an end-run reset holds the software-visible registers and fifo pointers; with enable set and begin clear
  // this is the required keep, otherwise holding is one legal undefined value
  wire clear_all = rst && !end_run_reset;
  wire keep_all = rst && end_run_reset;

  // ----------------------------------------
  // register state
  // ----------------------------------------
  logic [7:0] cmp_b_addr_low_reg;
  logic [7:0] cmp_c_addr_high_reg;
  logic [7:0] cmp_c_addr_low_reg;
  logic [7:0] cmp_a_direction_ext_reg;
  logic [7:0] debug_ctrl_reg;
  logic [FIFO_AW-1:0] rd_ptr_reg;
  logic [FIFO_AW-1:0] wr_ptr_reg;
  logic [FIFO_AW:0] fifo_count_reg;
  logic [FIFO_W-1:0] fifo_word;
  logic word_bypass_reg;
  logic [FIFO_W-1:0] bypass_word_reg;

  // ----------------------------------------
  // apb decode
  // ----------------------------------------
  wire setup = psel && !penable;
  wire fire = psel && penable && pready;
  wire wr_fire = fire && pwrite;
  wire rd_fire = fire && !pwrite;
  wire sel_cbl = (paddr == dbgcf_byte_addr(IDX_CMP_B_ADDR_LOW));
  wire sel_cch = (paddr == dbgcf_byte_addr(IDX_CMP_C_ADDR_HIGH));
  wire sel_ccl = (paddr == dbgcf_byte_addr(IDX_CMP_C_ADDR_LOW));
  wire sel_fh = (paddr == dbgcf_byte_addr(IDX_TRACE_FIFO_HIGH));
  wire sel_fl = (paddr == dbgcf_byte_addr(IDX_TRACE_FIFO_LOW));
  wire sel_cax = (paddr == dbgcf_byte_addr(IDX_CMP_A_DIRECTION_EXT));
  wire sel_ctl = (paddr == dbgcf_byte_addr(IDX_DEBUG_CTRL));
  wire sel_stat = (paddr == dbgcf_byte_addr(IDX_FIFO_STATUS));
  wire mapped = sel_cbl || sel_cch || sel_ccl || sel_fh || sel_fl
                || sel_cax || sel_ctl || sel_stat;

  // ----------------------------------------
  // control fields
  // ----------------------------------------
  wire debug_unit_enable = debug_ctrl_reg[CTRL_ENABLE_BIT];
  wire [1:0] mode_bits = debug_ctrl_reg[CTRL_MODE_LSB +: 2];
  wire full_mode = (mode_bits == DBGCF_MODE_FULL);
  wire event_mode = (mode_bits == DBGCF_MODE_EVENT);
  wire cmp_a_direction_enable = cmp_a_direction_ext_reg[CAX_DIR_EN_BIT];
  wire cmp_a_direction_value = cmp_a_direction_ext_reg[CAX_DIR_VAL_BIT];

  // ----------------------------------------
  // fifo pointers
  // ----------------------------------------
  wire fifo_empty = (fifo_count_reg == '0);
  wire fifo_full = (fifo_count_reg == (FIFO_AW+1)'(1 << FIFO_AW));
  // new words are dropped when full so older history is not overwritten
  wire fifo_push = trace_valid && !fifo_full;
  // a low-byte read of an empty fifo leaves the pointer where it is
  wire fifo_pop = rd_fire && sel_fl && !fifo_empty;
  wire [FIFO_AW-1:0] rd_ptr_next = fifo_pop ? rd_ptr_reg + 1'b1 : rd_ptr_reg;
  wire [FIFO_AW-1:0] wr_ptr_next = fifo_push ? wr_ptr_reg + 1'b1 : wr_ptr_reg;
  wire [FIFO_AW:0] fifo_count_next =
    fifo_push && !fifo_pop ? fifo_count_reg + 1'b1 :
    fifo_pop && !fifo_push ? fifo_count_reg - 1'b1 : fifo_count_reg;
  // a push into the slot that the read port is fetching reaches the read register
  // one cycle late, so that word is forwarded from a copy for that one cycle
  wire word_bypass_next = fifo_push && (wr_ptr_reg == rd_ptr_next);
  wire [FIFO_W-1:0] head_word = word_bypass_reg ? bypass_word_reg : fifo_word;

  // ----------------------------------------
  // register write values
  // ----------------------------------------
  // the fifo read-out bytes have no write path at all
  wire [7:0] wbyte = pwdata[7:0];
  wire [7:0] cbl_next = (wr_fire && sel_cbl) ? wbyte : cmp_b_addr_low_reg;
  wire [7:0] cch_next = (wr_fire && sel_cch) ? wbyte : cmp_c_addr_high_reg;
  wire [7:0] ccl_next = (wr_fire && sel_ccl) ? wbyte : cmp_c_addr_low_reg;
  wire [7:0] cax_next = (wr_fire && sel_cax) ? (wbyte & CAX_WRITE_MASK)
                        : cmp_a_direction_ext_reg;
  wire [7:0] ctl_next = (wr_fire && sel_ctl) ? (wbyte & CTRL_WRITE_MASK)
                        : debug_ctrl_reg;

  // ----------------------------------------
  // read-out values
  // ----------------------------------------
  wire [7:0] fifo_high_readout = (event_mode || fifo_empty) ? BYTE_ZERO
                                 : head_word[15:8];
  wire [7:0] fifo_low_readout = fifo_empty ? BYTE_ZERO : head_word[7:0];
  wire [7:0] stat_byte = {fifo_empty, fifo_full,
                          (6)'(fifo_count_reg)};
  wire [7:0] rd_byte =
    sel_cbl ? cmp_b_addr_low_reg :
    sel_cch ? cmp_c_addr_high_reg :
    sel_ccl ? cmp_c_addr_low_reg :
    sel_fh ? fifo_high_readout :
    sel_fl ? fifo_low_readout :
    sel_cax ? cmp_a_direction_ext_reg :
    sel_ctl ? debug_ctrl_reg :
    sel_stat ? stat_byte : BYTE_ZERO;

  // ----------------------------------------
  // software-visible registers and fifo pointers
  // ----------------------------------------
  // comparator b low byte: clear on ordinary reset, hold across an end-run reset
  always_ff @(posedge clk_sys) begin
    if (clear_all) begin
      cmp_b_addr_low_reg <= BYTE_ZERO;
    end else if (!keep_all) begin
      cmp_b_addr_low_reg <= cbl_next;
    end
  end

  // comparator c high byte
  always_ff @(posedge clk_sys) begin
    if (clear_all) begin
      cmp_c_addr_high_reg <= BYTE_ZERO;
    end else if (!keep_all) begin
      cmp_c_addr_high_reg <= cch_next;
    end
  end

  // comparator c low byte
  always_ff @(posedge clk_sys) begin
    if (clear_all) begin
      cmp_c_addr_low_reg <= BYTE_ZERO;
    end else if (!keep_all) begin
      cmp_c_addr_low_reg <= ccl_next;
    end
  end

  // comparator a direction bits
  always_ff @(posedge clk_sys) begin
    if (clear_all) begin
      cmp_a_direction_ext_reg <= BYTE_ZERO;
    end else if (!keep_all) begin
      cmp_a_direction_ext_reg <= cax_next;
    end
  end

  // control byte; holding it keeps the unit armed through an end-run reset
  always_ff @(posedge clk_sys) begin
    if (clear_all) begin
      debug_ctrl_reg <= BYTE_ZERO;
    end else if (!keep_all) begin
      debug_ctrl_reg <= ctl_next;
    end
  end

  // read pointer: fifo pointers follow the same reset classes as the registers
  always_ff @(posedge clk_sys) begin
    if (clear_all) begin
      rd_ptr_reg <= '0;
    end else if (!keep_all) begin
      rd_ptr_reg <= rd_ptr_next;
    end
  end

  // write pointer
  always_ff @(posedge clk_sys) begin
    if (clear_all) begin
      wr_ptr_reg <= '0;
    end else if (!keep_all) begin
      wr_ptr_reg <= wr_ptr_next;
    end
  end

  // fill level, kept apart from the pointers so full and empty need no pointer compare
  always_ff @(posedge clk_sys) begin
    if (clear_all) begin
      fifo_count_reg <= '0;
    end else if (!keep_all) begin
      fifo_count_reg <= fifo_count_next;
    end
  end

  // ----------------------------------------
  // apb answer
  // ----------------------------------------
  // no wait state: data is captured in setup, answered in the first access cycle
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= '0;
    end else begin
      pready <= setup;
      pslverr <= setup && !mapped;
      if (setup && !pwrite) begin
        prdata <= {{(DBGCF_DW-8){1'b0}}, rd_byte};
      end
    end
  end

  // ----------------------------------------
  // fifo storage
  // ----------------------------------------
  // read address is the next pointer, so the word is ready the cycle after a pop
  dbgcf_mem #(
    .WIDTH(FIFO_W),
    .AW(FIFO_AW)
  ) u_mem (
    .clk_sys(clk_sys),
    .wr_en(fifo_push && !rst),
    .wr_addr(wr_ptr_reg),
    .wr_data(trace_word),
    .rd_addr(rd_ptr_next),
    .rd_data(fifo_word)
  );

  // forwarding flag; a reset drops it since no write lands during reset
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      word_bypass_reg <= 1'b0;
    end else begin
      word_bypass_reg <= word_bypass_next;
    end
  end

  // copy of the last offered word; the flag decides whether it is used
  always_ff @(posedge clk_sys) begin
    bypass_word_reg <= trace_word;
  end

  // ----------------------------------------
  // comparators
  // ----------------------------------------
  // secured part or a running bdm command silences every comparator
  wire cmp_active = debug_unit_enable && !mcu_secure && !bdm_cmd_active;
  // in full mode comparator a's direction bits replace comparator b's own
  wire b_dir_en = full_mode ? cmp_a_direction_enable : cmp_b_dir_enable;
  wire b_dir_val = full_mode ? cmp_a_direction_value : cmp_b_dir_value;
  wire dbgcf_cmp_t cfg_a = '{dir_en: cmp_a_direction_enable,
                             dir_val: cmp_a_direction_value,
                             addr: cmp_a_addr};
  wire dbgcf_cmp_t cfg_b = '{dir_en: b_dir_en, dir_val: b_dir_val,
                             addr: {cmp_b_addr_high, cmp_b_addr_low_reg}};
  wire dbgcf_cmp_t cfg_c = '{dir_en: 1'b0, dir_val: 1'b0,
                             addr: {cmp_c_addr_high_reg, cmp_c_addr_low_reg}};

  dbgcf_cmp u_cmp_a (
    .clk_sys(clk_sys),
    .rst(rst),
    .active(cmp_active),
    .bus(cpu_bus),
    .cfg(cfg_a),
    .match(cmp_a_match)
  );

  dbgcf_cmp u_cmp_b (
    .clk_sys(clk_sys),
    .rst(rst),
    .active(cmp_active),
    .bus(cpu_bus),
    .cfg(cfg_b),
    .match(cmp_b_match)
  );

  dbgcf_cmp u_cmp_c (
    .clk_sys(clk_sys),
    .rst(rst),
    .active(cmp_active),
    .bus(cpu_bus),
    .cfg(cfg_c),
    .match(cmp_c_match)
  );

endmodule
`default_nettype wire

/* test/dbgcf_chk.sv */
// port-level checker for the debug comparator register block
`timescale 1ns/1ps
`default_nettype none
module dbgcf_chk
  import dbgcf_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [dbgcf_pkg::DBGCF_DW-1:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic mcu_secure,
  input wire logic bdm_cmd_active,
  input wire dbgcf_pkg::dbgcf_bus_t cpu_bus,
  input wire logic cmp_a_match,
  input wire logic cmp_b_match,
  input wire logic cmp_c_match
);
  wire [2:0] hit_vec;
  // all three comparator outputs seen together
  assign hit_vec = {cmp_a_match, cmp_b_match, cmp_c_match};
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  chk_ready_setup:
    assert property (psel && !penable |=> pready)
    else $error("no ready after setup");
  chk_ready_once:
    assert property (pready |-> psel && penable ##1 !pready)
    else $error("ready outside one access cycle");
  chk_err_ready:
    assert property (pslverr |-> pready)
    else $error("error without ready");
  chk_upper_zero:
    assert property (pready && !pwrite |-> prdata[31:8] == 24'h0)
    else $error("upper read bits set");
  chk_unmapped_zero:
    assert property (pslverr && !pwrite |-> prdata == 32'h0)
    else $error("unmapped read not zero");
  chk_secure_quiet:
    assert property (mcu_secure |=> hit_vec == 3'b000)
    else $error("match while secured");
  chk_bdm_quiet:
    assert property (bdm_cmd_active |=> hit_vec == 3'b000)
    else $error("match during bdm command");
  chk_reset_idle:
    assert property (disable iff (1'b0) rst |=> !pready && hit_vec == 3'b000)
    else $error("outputs active after reset");
  chk_idle_quiet:
    assert property (!cpu_bus.valid |=> hit_vec == 3'b000)
    else $error("match without a bus cycle");
endmodule
bind dbgcf_top dbgcf_chk i_dbgcf_chk (
  .clk_sys(clk_sys),
  .rst(rst),
  .psel(psel),
  .penable(penable),
  .pwrite(pwrite),
  .prdata(prdata),
  .pready(pready),
  .pslverr(pslverr),
  .mcu_secure(mcu_secure),
  .bdm_cmd_active(bdm_cmd_active),
  .cpu_bus(cpu_bus),
  .cmp_a_match(cmp_a_match),
  .cmp_b_match(cmp_b_match),
  .cmp_c_match(cmp_c_match)
);
`default_nettype wire

/* test/dbgcf_cpu_model.sv */
// behavioural model of the monitored cpu bus and trace source
`timescale 1ns/1ps
`default_nettype none
module dbgcf_cpu_model
  import dbgcf_pkg::*;
(
  input wire logic clk_sys,
  output var dbgcf_pkg::dbgcf_bus_t cpu_bus,
  output logic trace_valid,
  output logic [15:0] trace_word
);
  // idle bus, nothing pushed
  initial begin
    cpu_bus = '{valid: 1'b0, rw: 1'b0, addr: 16'hFFFF};
    trace_valid = 1'b0;
    trace_word = 16'h0000;
  end
  // one cycle, then inverted leftovers so a stale value never matches
  task automatic cpu_cycle(input logic [15:0] a, input logic r);
    @(posedge clk_sys);
    cpu_bus <= '{valid: 1'b1, rw: r, addr: a};
    @(posedge clk_sys);
    cpu_bus <= '{valid: 1'b0, rw: ~r, addr: ~a};
  endtask
  // one trace word per pulse
  task automatic push(input logic [15:0] w);
    @(posedge clk_sys);
    trace_valid <= 1'b1;
    trace_word <= w;
    @(posedge clk_sys);
    trace_valid <= 1'b0;
    trace_word <= ~w;
  endtask
endmodule
`default_nettype wire

/* test/dbgcf_top_bench.sv */
// self-checking bench for the debug comparator and trace fifo registers
`timescale 1ns/1ps
`default_nettype none
module dbgcf_top_bench;
  import dbgcf_pkg::*;
  // ----
  // stimulus and observation
  // ----
  localparam logic [15:0] R_BL = {IDX_CMP_B_ADDR_LOW, 2'b00};
  localparam logic [15:0] R_CH = {IDX_CMP_C_ADDR_HIGH, 2'b00};
  localparam logic [15:0] R_CL = {IDX_CMP_C_ADDR_LOW, 2'b00};
  localparam logic [15:0] R_FH = {IDX_TRACE_FIFO_HIGH, 2'b00};
  localparam logic [15:0] R_FL = {IDX_TRACE_FIFO_LOW, 2'b00};
  localparam logic [15:0] R_CX = {IDX_CMP_A_DIRECTION_EXT, 2'b00};
  localparam logic [15:0] R_CTL = {IDX_DEBUG_CTRL, 2'b00};
  localparam logic [15:0] R_ST = {IDX_FIFO_STATUS, 2'b00};
  logic [15:0] regs [6] = '{R_BL, R_CH, R_CL, R_FH, R_FL, R_CX};
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic end_run_reset = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr, err;
  logic [15:0] paddr = 16'h0;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic mcu_secure = 1'b0, bdm_cmd_active = 1'b0;
  logic cmp_b_dir_enable = 1'b0, cmp_b_dir_value = 1'b0;
  logic cmp_a_match, cmp_b_match, cmp_c_match, trace_valid;
  logic [15:0] trace_word;
  dbgcf_bus_t cpu_bus;
  int err_count = 0, n_checks = 0;
  // 50 MHz system clock
  always #10 clk_sys = ~clk_sys;
  dbgcf_top i_dbgcf_top (
    .clk_sys(clk_sys),
    .rst(rst),
    .end_run_reset(end_run_reset),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .mcu_secure(mcu_secure),
    .bdm_cmd_active(bdm_cmd_active),
    .cpu_bus(cpu_bus),
    .cmp_a_addr(16'h4000),
    .cmp_b_addr_high(8'h12),
    .cmp_b_dir_enable(cmp_b_dir_enable),
    .cmp_b_dir_value(cmp_b_dir_value),
    .trace_valid(trace_valid),
    .trace_word(trace_word),
    .cmp_a_match(cmp_a_match),
    .cmp_b_match(cmp_b_match),
    .cmp_c_match(cmp_c_match)
  );
  dbgcf_cpu_model i_dbgcf_cpu_model (
    .clk_sys(clk_sys),
    .cpu_bus(cpu_bus),
    .trace_valid(trace_valid),
    .trace_word(trace_word)
  );
  // ----
  // tasks
  // ----
  task automatic end_of_test();
    if (err_count == 0 && n_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic check_word(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %0t data %h exp %h", $time, got, exp);
    end
  endtask
  task automatic check_hits(input logic [2:0] exp);
    n_checks++;
    if ({cmp_a_match, cmp_b_match, cmp_c_match} !== exp) begin
      err_count++;
      $display("[FAIL] %0t hits %h exp %h", $time, {cmp_a_match, cmp_b_match, cmp_c_match}, exp);
    end
  endtask
  // apb transfer, request held until ready is sampled high
  task automatic apb(input logic wr, input logic [15:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge clk_sys);
    penable <= 1'b1;
    do begin
      @(posedge clk_sys);
      n++;
    end while (pready !== 1'b1 && n < 16);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      err_count++;
      end_of_test();
    end
  endtask
  task automatic rd_chk(input logic [15:0] a, input logic [7:0] e);
    apb(1'b0, a, 8'h00);
    check_word(rd, {24'h0, e});
  endtask
  // matches land one cycle after the sampled cpu cycle
  task automatic hit(input logic [15:0] a, input logic r, input logic [2:0] e);
    i_dbgcf_cpu_model.cpu_cycle(a, r);
    #1;
    check_hits(e);
  endtask
  task automatic do_reset(input logic erun);
    @(posedge clk_sys);
    end_run_reset <= erun;
    rst <= 1'b1;
    repeat (2) @(posedge clk_sys);
    rst <= 1'b0;
    end_run_reset <= 1'b0;
  endtask
  // ----
  // main sequence
  // ----
  initial begin
    repeat (10) @(posedge clk_sys);
    rst <= 1'b0;
    for (int i = 0; i < 6; i++) rd_chk(regs[i], 8'h00);
    apb(1'b0, 16'h6400, 8'h00);
    check_word({31'h0, err}, 32'h1);
    apb(1'b1, R_BL, 8'h5A);
    apb(1'b1, R_CH, 8'hA5);
    apb(1'b1, R_CL, 8'h3C);
    apb(1'b1, R_CX, 8'hFF);
    apb(1'b1, R_FH, 8'h77);
    rd_chk(R_BL, 8'h5A);
    rd_chk(R_CH, 8'hA5);
    rd_chk(R_CL, 8'h3C);
    rd_chk(R_CX, 8'hC0);
    rd_chk(R_FH, 8'h00);
    apb(1'b1, R_CTL, 8'h80);
    hit(16'hA53C, 1'b0, 3'b001);
    hit(16'hA53D, 1'b1, 3'b000);
    hit(16'hA43C, 1'b1, 3'b000);
    hit(16'h125A, 1'b1, 3'b010);
    hit(16'h125B, 1'b1, 3'b000);
    hit(16'h4000, 1'b1, 3'b100);
    hit(16'h4000, 1'b0, 3'b000);
    apb(1'b1, R_CX, 8'h80);
    hit(16'h4000, 1'b0, 3'b100);
    hit(16'h4000, 1'b1, 3'b000);
    apb(1'b1, R_CX, 8'h40);
    hit(16'h4000, 1'b0, 3'b100);
    hit(16'h4000, 1'b1, 3'b100);
    apb(1'b1, R_CX, 8'h80);
    apb(1'b1, R_CTL, 8'h81);
    cmp_b_dir_enable <= 1'b1;
    cmp_b_dir_value <= 1'b1;
    hit(16'h125A, 1'b0, 3'b010);
    hit(16'h125A, 1'b1, 3'b000);
    mcu_secure <= 1'b1;
    hit(16'hA53C, 1'b1, 3'b000);
    mcu_secure <= 1'b0;
    bdm_cmd_active <= 1'b1;
    hit(16'hA53C, 1'b1, 3'b000);
    bdm_cmd_active <= 1'b0;
    hit(16'hA53C, 1'b1, 3'b001);
    i_dbgcf_cpu_model.push(16'h1234);
    i_dbgcf_cpu_model.push(16'hABCD);
    i_dbgcf_cpu_model.push(16'h56EF);
    rd_chk(R_ST, 8'h03);
    rd_chk(R_FH, 8'h12);
    rd_chk(R_FH, 8'h12);
    rd_chk(R_FL, 8'h34);
    apb(1'b1, R_FL, 8'h00);
    rd_chk(R_FH, 8'hAB);
    rd_chk(R_FL, 8'hCD);
    apb(1'b1, R_CTL, 8'h82);
    rd_chk(R_FH, 8'h00);
    rd_chk(R_FL, 8'hEF);
    rd_chk(R_FL, 8'h00);
    apb(1'b1, R_CTL, 8'h80);
    do_reset(1'b1);
    rd_chk(R_BL, 8'h5A);
    rd_chk(R_CH, 8'hA5);
    do_reset(1'b0);
    for (int i = 0; i < 6; i++) rd_chk(regs[i], 8'h00);
    end_of_test();
  end
endmodule
`default_nettype wire
